// [src/csc_pkg.sv]
// Purpose: shared constants and types of the string compare and search unit
// Assumes: lengths are unsigned 16-bit words, registers are 32 bits
// Notes: opcodes are the 8-bit first-byte codes of the instructions
package csc_pkg;
  localparam logic [7:0] CSC_OP_CMP_EQ_LEN = 8'h29;
  localparam logic [7:0] CSC_OP_CMP_FILL = 8'h2D;
  localparam logic [7:0] CSC_OP_MATCH = 8'h39;
  localparam logic [7:0] CSC_OP_LOCATE = 8'h3A;
  localparam int CSC_LEN_W = 16;
  localparam int CSC_REG_W = 32;
  localparam int CSC_ADDR_W = 32;
  localparam int CSC_ADDR_W_MIN = 16;
  localparam logic [15:0] CSC_LEN_ONE = 16'h0001;
  localparam logic [15:0] CSC_LEN_ZERO = 16'h0000;
  localparam logic [31:0] CSC_REG_RST = 32'h0000_0000;
  localparam logic [7:0] CSC_BYTE_RST = 8'h00;
  localparam logic CSC_CC_Z_RST = 1'b1;

  typedef enum logic [2:0] {
    CSC_S_IDLE = 3'b000,
    CSC_S_CHECK = 3'b001,
    CSC_S_READ_A = 3'b010,
    CSC_S_READ_B = 3'b011,
    CSC_S_EVAL = 3'b100
  } csc_state_e;
endpackage : csc_pkg

// [src/csc_cmp_if.sv]
// Purpose: carrier between the sequencer and the byte comparator
// Assumes: purely combinational results
// Notes: user drives the two bytes, unit returns the relations
`timescale 1ns/1ns
`default_nettype none
interface csc_cmp_if;
  logic [7:0] a;
  logic [7:0] b;
  logic eq;
  logic slt;
  logic ult;
  modport unit (input a, input b, output eq, output slt, output ult);
  modport user (output a, output b, input eq, input slt, input ult);
endinterface : csc_cmp_if
`default_nettype wire

// [src/csc_byte_cmp.sv]
// Purpose: compares two bytes as signed and unsigned values
// Assumes: a is the first string byte, b the second
// Notes: results feed the condition codes directly
`timescale 1ns/1ns
`default_nettype none
module csc_byte_cmp (
  csc_cmp_if.unit cmp
);
  assign cmp.eq = (cmp.a == cmp.b);
  assign cmp.slt = ($signed(cmp.a) < $signed(cmp.b));
  assign cmp.ult = (cmp.a < cmp.b);
endmodule : csc_byte_cmp
`default_nettype wire

// [src/csc_unit.sv]
// Purpose: sequencer for string compare, locate and substring match
// Assumes: memory answers each byte request with a one-cycle ack
// Notes: suspends between bytes when an interrupt is pending
`timescale 1ns/1ns
`default_nettype none
module csc_unit #(
  parameter int ADDR_W = csc_pkg::CSC_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic subset_en,
  input wire logic fpd_in,
  input wire logic [15:0] len1_in,
  input wire logic [ADDR_W-1:0] addr1_in,
  input wire logic [15:0] len2_in,
  input wire logic [ADDR_W-1:0] addr2_in,
  input wire logic [15:0] obj_len_in,
  input wire logic [7:0] byte_in,
  input wire logic irq_pending,
  input wire logic mem_ack,
  input wire logic [7:0] mem_data,
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  output logic busy,
  output logic done,
  output logic emul_exc,
  output logic fpd_out,
  output logic cc_n,
  output logic cc_z,
  output logic cc_v,
  output logic cc_c,
  output logic [31:0] r0,
  output logic [31:0] r1,
  output logic [31:0] r2,
  output logic [31:0] r3,
  output logic [31:0] r4
);
  localparam logic [ADDR_W-1:0] A_ONE = ADDR_W'(1);

  generate
    if (ADDR_W < csc_pkg::CSC_ADDR_W_MIN || ADDR_W > csc_pkg::CSC_REG_W)
    begin : g_bad_width
      $error("csc_unit: ADDR_W out of range");
    end
  endgenerate

  function automatic logic [ADDR_W-1:0] zx(input logic [15:0] v);
    zx = ADDR_W'(v);
  endfunction : zx

  function automatic logic [31:0] rx(input logic [ADDR_W-1:0] v);
    rx = 32'(v);
  endfunction : rx

  csc_pkg::csc_state_e state_reg, state_next;
  logic [7:0] op_reg, op_next, fill_reg, fill_next;
  logic [7:0] a_reg, a_next, b_reg, b_next;
  logic [15:0] len1_reg, len1_next, len2_reg, len2_next;
  logic [15:0] obj_reg, obj_next;
  logic [ADDR_W-1:0] addr1_reg, addr1_next, addr2_reg, addr2_next;
  logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
  logic mem_req_reg, mem_req_next, stop_reg, stop_next;
  logic busy_reg, busy_next, done_reg, done_next;
  logic emul_reg, emul_next, fpd_reg, fpd_next;
  logic n_reg, n_next, z_reg, z_next, v_reg, v_next, c_reg, c_next;
  logic [31:0] r0_reg, r0_next, r1_reg, r1_next, r2_reg, r2_next;
  logic [31:0] r3_reg, r3_next, r4_reg, r4_next;

  csc_cmp_if cmp_bus ();
  csc_byte_cmp u_cmp (.cmp(cmp_bus));
  assign cmp_bus.a = a_reg;
  assign cmp_bus.b = b_reg;

  wire logic in_c3 = (opcode == csc_pkg::CSC_OP_CMP_EQ_LEN);
  wire logic in_c5 = (opcode == csc_pkg::CSC_OP_CMP_FILL);
  wire logic in_mt = (opcode == csc_pkg::CSC_OP_MATCH);
  wire logic in_lc = (opcode == csc_pkg::CSC_OP_LOCATE);
  wire logic in_known = in_c3 | in_c5 | in_mt | in_lc;
  wire logic is_c3 = (op_reg == csc_pkg::CSC_OP_CMP_EQ_LEN);
  wire logic is_c5 = (op_reg == csc_pkg::CSC_OP_CMP_FILL);
  wire logic is_mt = (op_reg == csc_pkg::CSC_OP_MATCH);
  wire logic is_lc = (op_reg == csc_pkg::CSC_OP_LOCATE);
  wire logic len1_nz = (len1_reg != csc_pkg::CSC_LEN_ZERO);
  wire logic len2_nz = (len2_reg != csc_pkg::CSC_LEN_ZERO);
  wire logic src_short = (len2_reg < len1_reg);
  // bytes of the object already matched, undone on a mismatch
  wire logic [15:0] rewind = obj_reg - len1_reg;
  wire logic cont = is_c5 ? (len1_nz | len2_nz) :
                    is_mt ? (len1_nz & !src_short) : len1_nz;
  wire logic need_a = is_c5 ? len1_nz : 1'b1;
  wire logic need_b = is_c3 | is_mt | (is_c5 & len2_nz);
  wire logic yield_now = cont & !stop_reg & irq_pending;

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    fill_next = fill_reg;
    a_next = a_reg;
    b_next = b_reg;
    len1_next = len1_reg;
    len2_next = len2_reg;
    obj_next = obj_reg;
    addr1_next = addr1_reg;
    addr2_next = addr2_reg;
    mem_addr_next = mem_addr_reg;
    mem_req_next = mem_req_reg;
    stop_next = stop_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    emul_next = 1'b0;
    fpd_next = fpd_reg;
    n_next = n_reg;
    z_next = z_reg;
    v_next = v_reg;
    c_next = c_reg;
    r0_next = r0_reg;
    r1_next = r1_reg;
    r2_next = r2_reg;
    r3_next = r3_reg;
    r4_next = r4_reg;
    case (state_reg)
      csc_pkg::CSC_S_IDLE: begin
        if (start) begin
          if (subset_en || !in_known) begin
            emul_next = 1'b1;
          end else begin
            // resume takes fresh operands; fpd_in only selects obj_len_in as the object length
            op_next = opcode;
            fill_next = byte_in;
            len1_next = len1_in;
            addr1_next = addr1_in;
            len2_next = len2_in;
            addr2_next = addr2_in;
            obj_next = fpd_in ? obj_len_in : len1_in;
            stop_next = 1'b0;
            busy_next = 1'b1;
            fpd_next = 1'b0;
            n_next = 1'b0;
            z_next = csc_pkg::CSC_CC_Z_RST;
            v_next = 1'b0;
            c_next = 1'b0;
            state_next = csc_pkg::CSC_S_CHECK;
          end
        end
      end
      csc_pkg::CSC_S_CHECK: begin
        if (!cont || stop_reg || yield_now) begin
          r0_next = {16'h0000, len1_reg};
          r1_next = rx(addr1_reg);
          r2_next = is_c3 ? {16'h0000, len1_reg}
                          : {16'h0000, len2_reg};
          r3_next = rx(addr2_reg);
          r4_next = {16'h0000, obj_reg};
          if (is_mt && src_short && !yield_now) begin
            r2_next = csc_pkg::CSC_REG_RST;
            r3_next = rx(addr2_reg + zx(len2_reg));
          end
          if (is_lc || is_mt) begin
            n_next = 1'b0;
            z_next = !len1_nz;
            v_next = 1'b0;
            c_next = 1'b0;
          end
          fpd_next = yield_now;
          done_next = 1'b1;
          busy_next = 1'b0;
          state_next = csc_pkg::CSC_S_IDLE;
        end else begin
          // the side not read from memory is the fill or search byte
          a_next = fill_reg;
          b_next = fill_reg;
          mem_req_next = 1'b1;
          mem_addr_next = need_a ? addr1_reg : addr2_reg;
          state_next = need_a ? csc_pkg::CSC_S_READ_A
                              : csc_pkg::CSC_S_READ_B;
        end
      end
      csc_pkg::CSC_S_READ_A: begin
        if (mem_ack) begin
          a_next = mem_data;
          if (need_b) begin
            mem_addr_next = addr2_reg;
            state_next = csc_pkg::CSC_S_READ_B;
          end else begin
            mem_req_next = 1'b0;
            state_next = csc_pkg::CSC_S_EVAL;
          end
        end
      end
      csc_pkg::CSC_S_READ_B: begin
        if (mem_ack) begin
          b_next = mem_data;
          mem_req_next = 1'b0;
          state_next = csc_pkg::CSC_S_EVAL;
        end
      end
      csc_pkg::CSC_S_EVAL: begin
        state_next = csc_pkg::CSC_S_CHECK;
        if (is_c3 || is_c5) begin
          n_next = cmp_bus.slt;
          z_next = cmp_bus.eq;
          v_next = 1'b0;
          c_next = cmp_bus.ult;
          if (!cmp_bus.eq) begin
            stop_next = 1'b1;
          end else begin
            if (len1_nz) begin
              len1_next = len1_reg - csc_pkg::CSC_LEN_ONE;
              addr1_next = addr1_reg + A_ONE;
            end
            if (is_c5 && len2_nz) begin
              len2_next = len2_reg - csc_pkg::CSC_LEN_ONE;
            end
            if (is_c3 || len2_nz) begin
              addr2_next = addr2_reg + A_ONE;
            end
          end
        end else if (is_lc) begin
          if (cmp_bus.eq) begin
            stop_next = 1'b1;
          end else begin
            len1_next = len1_reg - csc_pkg::CSC_LEN_ONE;
            addr1_next = addr1_reg + A_ONE;
          end
        end else if (cmp_bus.eq) begin
          len1_next = len1_reg - csc_pkg::CSC_LEN_ONE;
          addr1_next = addr1_reg + A_ONE;
          len2_next = len2_reg - csc_pkg::CSC_LEN_ONE;
          addr2_next = addr2_reg + A_ONE;
        end else begin
          addr1_next = addr1_reg - zx(rewind);
          len2_next = len2_reg - csc_pkg::CSC_LEN_ONE + rewind;
          addr2_next = addr2_reg + A_ONE - zx(rewind);
          len1_next = obj_reg;
        end
      end
      default: begin
        state_next = csc_pkg::CSC_S_IDLE;
        mem_req_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= csc_pkg::CSC_S_IDLE;
      {op_reg, fill_reg, a_reg, b_reg} <= {4{csc_pkg::CSC_BYTE_RST}};
      {len1_reg, len2_reg, obj_reg} <= {3{csc_pkg::CSC_LEN_ZERO}};
      addr1_reg <= '0;
      addr2_reg <= '0;
      mem_addr_reg <= '0;
      {mem_req_reg, stop_reg, busy_reg, done_reg} <= 4'h0;
      {emul_reg, fpd_reg, n_reg, v_reg, c_reg} <= 5'h00;
      z_reg <= csc_pkg::CSC_CC_Z_RST;
      {r0_reg, r1_reg, r2_reg} <= {3{csc_pkg::CSC_REG_RST}};
      {r3_reg, r4_reg} <= {2{csc_pkg::CSC_REG_RST}};
    end else begin
      state_reg <= state_next;
      {op_reg, fill_reg, a_reg, b_reg} <= {op_next, fill_next, a_next, b_next};
      {len1_reg, len2_reg, obj_reg} <= {len1_next, len2_next, obj_next};
      addr1_reg <= addr1_next;
      addr2_reg <= addr2_next;
      mem_addr_reg <= mem_addr_next;
      {mem_req_reg, stop_reg} <= {mem_req_next, stop_next};
      {busy_reg, done_reg} <= {busy_next, done_next};
      {emul_reg, fpd_reg, n_reg, v_reg, c_reg} <=
        {emul_next, fpd_next, n_next, v_next, c_next};
      z_reg <= z_next;
      {r0_reg, r1_reg, r2_reg} <= {r0_next, r1_next, r2_next};
      {r3_reg, r4_reg} <= {r3_next, r4_next};
    end
  end

  assign mem_req = mem_req_reg;
  assign mem_addr = mem_addr_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign emul_exc = emul_reg;
  assign fpd_out = fpd_reg;
  assign {cc_n, cc_z, cc_v, cc_c} = {n_reg, z_reg, v_reg, c_reg};
  assign {r0, r1, r2, r3, r4} = {r0_reg, r1_reg, r2_reg, r3_reg, r4_reg};

  property p_emul;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == csc_pkg::CSC_S_IDLE && start && subset_en)
      |=> (emul_exc && !busy);
  endproperty
  a_emul: assert property (p_emul) else $error("no emulation trap");

  property p_no_zero_ref;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == csc_pkg::CSC_S_READ_A) |-> len1_nz;
  endproperty
  a_no_zero_ref: assert property (p_no_zero_ref)
    else $error("read from empty string");

  property p_yield;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == csc_pkg::CSC_S_CHECK && yield_now)
      |=> (done && fpd_out && !busy);
  endproperty
  a_yield: assert property (p_yield) else $error("no yield");

  property p_req_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr));
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped early");

  property p_v_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    done |-> !cc_v;
  endproperty
  a_v_clear: assert property (p_v_clear) else $error("V set");

  property p_empty_equal;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == csc_pkg::CSC_S_IDLE && start && !subset_en && in_c3
      && len1_in == csc_pkg::CSC_LEN_ZERO)
      |-> ##2 (done && cc_z && !cc_n && !cc_c && !mem_req);
  endproperty
  a_empty_equal: assert property (p_empty_equal)
    else $error("empty strings not equal");

  property p_z_from_r0;
    @(posedge sys_clk) disable iff (!rst_n)
    (done && (is_lc || is_mt)) |-> (cc_z == (r0 == csc_pkg::CSC_REG_RST));
  endproperty
  a_z_from_r0: assert property (p_z_from_r0)
    else $error("Z disagrees with R0");

  property p_cmp_step;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == csc_pkg::CSC_S_EVAL && is_c3 && cmp_bus.eq)
      |=> (len1_reg == $past(len1_reg) - csc_pkg::CSC_LEN_ONE);
  endproperty
  a_cmp_step: assert property (p_cmp_step)
    else $error("compare did not advance");

  property p_rewind;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == csc_pkg::CSC_S_EVAL && is_mt && !cmp_bus.eq)
      |=> (len1_reg == obj_reg && state_reg == csc_pkg::CSC_S_CHECK);
  endproperty
  a_rewind: assert property (p_rewind) else $error("bad rewind");
endmodule : csc_unit
`default_nettype wire

// [verif/csc_mem_model.sv]
// Purpose: byte memory answering the string unit's read requests
// Assumes: one read in flight, ack is a one-cycle pulse with the data
// Notes: wait_cycles stretches each answer; idle data toggles each cycle
`timescale 1ns/1ns
`default_nettype none
module csc_mem_model #(
  parameter int ADDR_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [3:0] wait_cycles,
  output logic mem_ack,
  output logic [7:0] mem_data
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt;
  wire logic pend = mem_req && !mem_ack;

  // data is only good with ack; otherwise it keeps moving so stale reuse shows
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_data <= 8'h00;
      cnt <= 4'h0;
    end else if (pend && cnt >= wait_cycles) begin
      mem_ack <= 1'b1;
      mem_data <= mem[mem_addr[7:0]];
      cnt <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      cnt <= pend ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : csc_mem_model
`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench for the string compare and search unit
// Assumes: 16-bit addresses, memory bytes preloaded below 0x100
// Notes: each test is one instruction run with expected codes and registers, except the yield/resume pair and the emul_exc trap tests
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic subset_en = 1'b0;
  logic fpd_in = 1'b0;
  logic [15:0] len1_in = 16'h0000;
  logic [15:0] addr1_in = 16'h0000;
  logic [15:0] len2_in = 16'h0000;
  logic [15:0] addr2_in = 16'h0000;
  logic [15:0] obj_len_in = 16'h0000;
  logic [7:0] byte_in = 8'h00;
  logic irq_pending = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic req_seen = 1'b0;
  wire logic mem_ack, mem_req, busy, done, emul_exc, fpd_out;
  wire logic cc_n, cc_z, cc_v, cc_c;
  wire logic [7:0] mem_data;
  wire logic [15:0] mem_addr;
  wire logic [31:0] r0, r1, r2, r3, r4;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] ops [4] = '{8'h29, 8'h2D, 8'h39, 8'h3A};

  always #25 sys_clk = ~sys_clk;
  // one driver: cleared on the edge that takes start, so each run starts clean
  always @(posedge sys_clk) begin
    if (start) req_seen <= 1'b0;
    else if (mem_req === 1'b1) req_seen <= 1'b1;
  end

  csc_unit #(.ADDR_W(16)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .start(start), .opcode(opcode), .subset_en(subset_en),
    .fpd_in(fpd_in), .len1_in(len1_in), .addr1_in(addr1_in),
    .len2_in(len2_in), .addr2_in(addr2_in), .obj_len_in(obj_len_in),
    .byte_in(byte_in), .irq_pending(irq_pending), .mem_ack(mem_ack),
    .mem_data(mem_data), .mem_req(mem_req), .mem_addr(mem_addr),
    .busy(busy), .done(done), .emul_exc(emul_exc), .fpd_out(fpd_out),
    .cc_n(cc_n), .cc_z(cc_z), .cc_v(cc_v), .cc_c(cc_c),
    .r0(r0), .r1(r1), .r2(r2), .r3(r3), .r4(r4));

  csc_mem_model #(.ADDR_W(16)) mem_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_addr(mem_addr), .wait_cycles(wait_cycles),
    .mem_ack(mem_ack), .mem_data(mem_data));

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task chk(input string name, input logic [31:0] seen,
           input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one instruction: request held for a single edge, then wait for an answer
  task run(input logic [7:0] op, input logic [15:0] l1, a1, l2, a2,
           input logic [7:0] b);
    int i;
    @(posedge sys_clk);
    start <= 1'b1;
    opcode <= op;
    len1_in <= l1;
    addr1_in <= a1;
    len2_in <= l2;
    addr2_in <= a2;
    byte_in <= b;
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 500; i++) begin
      @(negedge sys_clk);
      if (done === 1'b1 || emul_exc === 1'b1) break;
    end
    if (i == 500) begin
      bad_count++;
      close_out;
    end
  endtask : run

  task res(input logic [3:0] nzvc, input logic [15:0] e0, e1, e2, e3);
    chk("nzvc", 32'({cc_n, cc_z, cc_v, cc_c}), 32'(nzvc));
    chk("r0", r0, 32'(e0));
    chk("r1", r1, 32'(e1));
    chk("r2", r2, 32'(e2));
    chk("r3", r3, 32'(e3));
  endtask : res

  initial begin
    mem_i.mem[8'h10] = 8'h41;
    mem_i.mem[8'h11] = 8'h42;
    mem_i.mem[8'h12] = 8'h43;
    mem_i.mem[8'h13] = 8'h44;
    mem_i.mem[8'h20] = 8'h41;
    mem_i.mem[8'h21] = 8'h42;
    mem_i.mem[8'h22] = 8'h58;
    mem_i.mem[8'h40] = 8'h80;
    mem_i.mem[8'h41] = 8'h01;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    run(8'h29, 16'h0004, 16'h0010, 16'h0000, 16'h0020, 8'h00);
    res(4'h9, 16'h0002, 16'h0012, 16'h0002, 16'h0022);
    run(8'h29, 16'h0000, 16'h0010, 16'h0000, 16'h0020, 8'h00);
    res(4'h4, 16'h0000, 16'h0010, 16'h0000, 16'h0020);
    chk("req", 32'(req_seen), 32'h0000_0000);
    run(8'h29, 16'h0001, 16'h0040, 16'h0000, 16'h0041, 8'h00);
    res(4'h8, 16'h0001, 16'h0040, 16'h0001, 16'h0041);
    run(8'h29, 16'h0001, 16'h0041, 16'h0000, 16'h0040, 8'h00);
    res(4'h1, 16'h0001, 16'h0041, 16'h0001, 16'h0040);
    run(8'h2D, 16'h0000, 16'h0010, 16'h0000, 16'h0020, 8'h55);
    res(4'h4, 16'h0000, 16'h0010, 16'h0000, 16'h0020);
    chk("req", 32'(req_seen), 32'h0000_0000);
    run(8'h2D, 16'h0004, 16'h0010, 16'h0002, 16'h0010, 8'h43);
    res(4'h0, 16'h0001, 16'h0013, 16'h0000, 16'h0012);
    // slow memory: every byte waits several cycles for its answer
    wait_cycles <= 4'h3;
    run(8'h2D, 16'h0002, 16'h0010, 16'h0004, 16'h0010, 8'h43);
    res(4'h9, 16'h0000, 16'h0012, 16'h0001, 16'h0013);
    run(8'h29, 16'h0004, 16'h0010, 16'h0000, 16'h0010, 8'h00);
    res(4'h4, 16'h0000, 16'h0014, 16'h0000, 16'h0014);
    wait_cycles <= 4'h0;
    run(8'h3A, 16'h0004, 16'h0010, 16'h0000, 16'h0000, 8'h43);
    res(4'h0, 16'h0002, 16'h0012, 16'h0000, 16'h0000);
    run(8'h3A, 16'h0000, 16'h0010, 16'h0000, 16'h0000, 8'h41);
    res(4'h4, 16'h0000, 16'h0010, 16'h0000, 16'h0000);
    chk("req", 32'(req_seen), 32'h0000_0000);
    run(8'h3A, 16'h0004, 16'h0010, 16'h0000, 16'h0000, 8'h5A);
    res(4'h4, 16'h0000, 16'h0014, 16'h0000, 16'h0000);
    run(8'h39, 16'h0002, 16'h0011, 16'h0004, 16'h0010, 8'h00);
    res(4'h4, 16'h0000, 16'h0013, 16'h0001, 16'h0013);
    run(8'h39, 16'h0002, 16'h0021, 16'h0004, 16'h0010, 8'h00);
    res(4'h0, 16'h0002, 16'h0021, 16'h0000, 16'h0014);
    run(8'h39, 16'h0000, 16'h0021, 16'h0004, 16'h0010, 8'h00);
    res(4'h4, 16'h0000, 16'h0021, 16'h0004, 16'h0010);
    run(8'h39, 16'h0002, 16'h0021, 16'h0000, 16'h0010, 8'h00);
    res(4'h0, 16'h0002, 16'h0021, 16'h0000, 16'h0010);
    // pending interrupt before the first byte: yield, then resume
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    run(8'h29, 16'h0004, 16'h0010, 16'h0000, 16'h0010, 8'h00);
    chk("fpd_out", 32'(fpd_out), 32'h0000_0001);
    chk("r0", r0, 32'h0000_0004);
    chk("r1", r1, 32'h0000_0010);
    chk("r3", r3, 32'h0000_0010);
    chk("r4", r4, 32'h0000_0004);
    chk("busy", 32'(busy), 32'h0000_0000);
    @(posedge sys_clk);
    irq_pending <= 1'b0;
    fpd_in <= 1'b1;
    run(8'h29, r0[15:0], r1[15:0], 16'h0000, r3[15:0], 8'h00);
    @(posedge sys_clk);
    fpd_in <= 1'b0;
    res(4'h4, 16'h0000, 16'h0014, 16'h0000, 16'h0014);
    chk("fpd_out", 32'(fpd_out), 32'h0000_0000);
    @(posedge sys_clk);
    subset_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      run(ops[k], 16'h0001, 16'h0010, 16'h0001, 16'h0020, 8'h41);
      chk("emul_exc", 32'(emul_exc), 32'h0000_0001);
      chk("done", 32'(done), 32'h0000_0000);
      chk("req", 32'(req_seen), 32'h0000_0000);
    end
    // a code this unit does not execute traps even in the full set
    @(posedge sys_clk);
    subset_en <= 1'b0;
    run(8'hFF, 16'h0001, 16'h0010, 16'h0001, 16'h0020, 8'h41);
    chk("emul_exc", 32'(emul_exc), 32'h0000_0001);
    chk("done", 32'(done), 32'h0000_0000);
    chk("req", 32'(req_seen), 32'h0000_0000);
    close_out;
  end
endmodule : testbench
`default_nettype wire
